// File: rtl/spce_map.svh
// spce_map.svh: offsets, field positions, codes and reset values of the
// per-port link control and link error registers.
// assumes: included by the register module by bare name.
//
// What this block does
// - the power transition allow field sits in control bits 11:8 and uses 0h none, 1h no partial, 2h no slumber, 3h neither.
// - the adapter never starts entry into a power state that the allow field disables.
// - a drive request for a disabled power state is answered with PMNAK_P.
// - the power state select field 15:12 and multiplier port field 19:16 read zero and ignore writes.
// - the low sixteen error bits reset to zero and each clears only when software writes a one to it.
// - an internal failure also raises a fatal or a non-fatal port interrupt status event.
// - any protocol violation on the port sets error bit 10.
// - while the detect init field holds 1h the port sends COMRESET, and software holds it there for at least 1 ms.
// - the speed limit field in bits 7:4 means 0h no limit, 1h generation 1 only, 2h at most generation 2.
`ifndef SPCE_MAP_SVH
`define SPCE_MAP_SVH

// ----------------------------------------
// register byte offsets in the port window
// ----------------------------------------
`define SPCE_OFS_LINK_CONTROL 8'h2C
`define SPCE_OFS_LINK_ERROR 8'h30

// ----------------------------------------
// control field layout and codes
// ----------------------------------------
`define SPCE_CTL_RESET 12'h000 // only bits 11:0 are stored
`define SPCE_CTL_WR_MASK 32'h0000_0FFF
`define SPCE_DETECT_INIT_LSB 0
`define SPCE_SPEED_LIMIT_LSB 4
`define SPCE_PWR_ALLOW_LSB 8
`define SPCE_DETECT_INIT_NONE 4'h0
`define SPCE_DETECT_INIT_COMRESET 4'h1
`define SPCE_DETECT_INIT_OFFLINE 4'h4
`define SPCE_PWR_ALLOW_NO_PARTIAL 4'h1
`define SPCE_PWR_ALLOW_NO_SLUMBER 4'h2
`define SPCE_PWR_ALLOW_NO_BOTH 4'h3

// ----------------------------------------
// error field layout
// ----------------------------------------
`define SPCE_ERR_RESET 16'h0000
`define SPCE_ERR_LIVE_MASK 16'h0F03
`define SPCE_ERR_INTERNAL 11
`define SPCE_ERR_PROTOCOL 10
`define SPCE_ERR_PERSIST_COMM 9
`define SPCE_ERR_TRANSIENT_DATA 8
`define SPCE_ERR_RECOV_COMM 1
`define SPCE_ERR_RECOV_DATA 0

`endif

// File: rtl/spce_pkg.sv
// spce_pkg.sv: types shared by the port link register block.
// assumes: single system clock; offsets live in spce_map.svh.
package spce_pkg;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // register window access
  // ----------------------------------------
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [31:0] wdata;
  } spce_reg_req_s;

  // ----------------------------------------
  // hardware error events, one-cycle pulses
  // ----------------------------------------
  typedef struct packed {
    logic mem_abort;
    logic elastic_ovf;
    logic prim_misalign;
    logic sync_fifo_ovf;
    logic internal_other;
    logic protocol;
    logic persist_comm;
    logic transient_data;
    logic recov_comm;
    logic recov_data;
  } spce_err_ev_s;

  // interface power states
  typedef enum logic {
    SPCE_PM_PARTIAL,
    SPCE_PM_SLUMBER
  } spce_pm_kind_e;

  // answer to a drive power request
  typedef enum logic [1:0] {
    SPCE_RPL_IDLE,
    SPCE_RPL_ACK,
    SPCE_RPL_NAK
  } spce_reply_e;

endpackage

// File: rtl/spce_port_regs.sv
// spce_port_regs.sv: per-port link control and link error registers,
// power state gating and the power request answer.
// assumes: register window, link layer and command engine all run on clk_i.
`include "spce_map.svh"

module spce_port_regs (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire spce_pkg::spce_reg_req_s reg_req_i,
  output logic [31:0] rd_data_o,
  output logic rd_valid_o,
  input wire spce_pkg::spce_err_ev_s err_ev_i,
  input wire logic err_fatal_i,
  input wire logic host_pm_req_i,
  input wire spce_pkg::spce_pm_kind_e host_pm_kind_i,
  output logic host_pm_go_o,
  input wire logic dev_pm_req_i,
  input wire spce_pkg::spce_pm_kind_e dev_pm_kind_i,
  output logic pmack_o,
  output logic pmnak_o,
  output logic comreset_o,
  output logic phy_offline_o,
  output logic [3:0] speed_limit_o,
  output logic irq_fatal_set_o,
  output logic irq_nonfatal_set_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // reserved allow codes are treated as disabling both states
  function automatic logic pm_allowed(input logic [3:0] allow, input spce_pkg::spce_pm_kind_e kind);
    logic blocked;
    blocked = 1'b0;
    case (allow)
      4'h0: blocked = 1'b0;
      `SPCE_PWR_ALLOW_NO_PARTIAL: blocked = (kind == spce_pkg::SPCE_PM_PARTIAL);
      `SPCE_PWR_ALLOW_NO_SLUMBER: blocked = (kind == spce_pkg::SPCE_PM_SLUMBER);
      `SPCE_PWR_ALLOW_NO_BOTH: blocked = 1'b1;
      default: blocked = 1'b1;
    endcase
    return !blocked;
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [11:0] ctl_reg;
  logic [11:0] ctl_next;
  logic [15:0] err_reg;
  logic [15:0] err_next;
  logic [31:0] rd_data_reg;
  logic [31:0] rd_data_next;
  logic rd_valid_reg;
  logic rd_valid_next;
  logic fatal_reg;
  logic fatal_next;
  logic nonfatal_reg;
  logic nonfatal_next;
  spce_pkg::spce_reply_e reply_reg;
  spce_pkg::spce_reply_e reply_next;

  logic wr_ctl;
  logic wr_err;
  logic rd_ctl;
  logic rd_err;
  logic internal_ev;
  logic [15:0] err_set;
  logic [3:0] pwr_allow;

  // window decode
  assign wr_ctl = reg_req_i.valid && reg_req_i.write && (reg_req_i.addr == `SPCE_OFS_LINK_CONTROL);
  assign wr_err = reg_req_i.valid && reg_req_i.write && (reg_req_i.addr == `SPCE_OFS_LINK_ERROR);
  assign rd_ctl = reg_req_i.valid && !reg_req_i.write && (reg_req_i.addr == `SPCE_OFS_LINK_CONTROL);
  assign rd_err = reg_req_i.valid && !reg_req_i.write && (reg_req_i.addr == `SPCE_OFS_LINK_ERROR);
  assign pwr_allow = ctl_reg[`SPCE_PWR_ALLOW_LSB +: 4];

  // any internal failure source
  assign internal_ev = err_ev_i.mem_abort || err_ev_i.elastic_ovf || err_ev_i.prim_misalign
    || err_ev_i.sync_fifo_ovf || err_ev_i.internal_other;

  // per-bit set vector from hardware events
  always_comb begin
    err_set = 16'h0000;
    err_set[`SPCE_ERR_INTERNAL] = internal_ev;
    err_set[`SPCE_ERR_PROTOCOL] = err_ev_i.protocol;
    err_set[`SPCE_ERR_PERSIST_COMM] = err_ev_i.persist_comm;
    err_set[`SPCE_ERR_TRANSIENT_DATA] = err_ev_i.transient_data;
    err_set[`SPCE_ERR_RECOV_COMM] = err_ev_i.recov_comm;
    err_set[`SPCE_ERR_RECOV_DATA] = err_ev_i.recov_data;
  end

  // ----------------------------------------
  // register next values
  // ----------------------------------------
  always_comb begin
    ctl_next = ctl_reg;
    err_next = err_reg;
    if (wr_ctl) begin
      ctl_next = reg_req_i.wdata[11:0];
    end
    if (wr_err) begin
      err_next = err_reg & ~reg_req_i.wdata[15:0];
    end
    err_next = (err_next | err_set) & `SPCE_ERR_LIVE_MASK;
  end

  // read data, unmapped offsets answer zero
  always_comb begin
    rd_valid_next = reg_req_i.valid && !reg_req_i.write;
    rd_data_next = 32'h0000_0000;
    if (rd_ctl) begin
      rd_data_next = {20'h0_0000, ctl_reg};
    end else if (rd_err) begin
      rd_data_next = {16'h0000, err_reg};
    end
  end

  // interrupt status events accompanying an internal failure
  always_comb begin
    fatal_next = internal_ev && err_fatal_i;
    nonfatal_next = internal_ev && !err_fatal_i;
  end

  // answer to a drive power request
  always_comb begin
    reply_next = spce_pkg::SPCE_RPL_IDLE;
    case (reply_reg)
      spce_pkg::SPCE_RPL_IDLE,
      spce_pkg::SPCE_RPL_ACK,
      spce_pkg::SPCE_RPL_NAK: begin
        if (dev_pm_req_i) begin
          if (pm_allowed(pwr_allow, dev_pm_kind_i)) begin
            reply_next = spce_pkg::SPCE_RPL_ACK;
          end else begin
            reply_next = spce_pkg::SPCE_RPL_NAK;
          end
        end
      end
      default: reply_next = spce_pkg::SPCE_RPL_IDLE;
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ctl_reg <= `SPCE_CTL_RESET;
      err_reg <= `SPCE_ERR_RESET;
      rd_data_reg <= 32'h0000_0000;
      rd_valid_reg <= 1'b0;
      fatal_reg <= 1'b0;
      nonfatal_reg <= 1'b0;
      reply_reg <= spce_pkg::SPCE_RPL_IDLE;
    end else begin
      ctl_reg <= ctl_next;
      err_reg <= err_next;
      rd_data_reg <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
      fatal_reg <= fatal_next;
      nonfatal_reg <= nonfatal_next;
      reply_reg <= reply_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign rd_data_o = rd_data_reg;
  assign rd_valid_o = rd_valid_reg;
  assign host_pm_go_o = host_pm_req_i && pm_allowed(pwr_allow, host_pm_kind_i);
  assign pmack_o = (reply_reg == spce_pkg::SPCE_RPL_ACK);
  assign pmnak_o = (reply_reg == spce_pkg::SPCE_RPL_NAK);
  assign comreset_o = (ctl_reg[`SPCE_DETECT_INIT_LSB +: 4] == `SPCE_DETECT_INIT_COMRESET);
  assign phy_offline_o = (ctl_reg[`SPCE_DETECT_INIT_LSB +: 4] == `SPCE_DETECT_INIT_OFFLINE);
  assign speed_limit_o = ctl_reg[`SPCE_SPEED_LIMIT_LSB +: 4];
  assign irq_fatal_set_o = fatal_reg;
  assign irq_nonfatal_set_o = nonfatal_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_no_partial_start: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (host_pm_go_o && host_pm_kind_i == spce_pkg::SPCE_PM_PARTIAL) |-> (pwr_allow == 4'h0 || pwr_allow == 4'h2))
    else $error("partial entry started while disabled");

  a_no_slumber_start: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (host_pm_go_o && host_pm_kind_i == spce_pkg::SPCE_PM_SLUMBER) |-> (pwr_allow == 4'h0 || pwr_allow == 4'h1))
    else $error("slumber entry started while disabled");

  a_nak_disabled_req: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (dev_pm_req_i && pwr_allow == 4'h3) |=> (pmnak_o && !pmack_o))
    else $error("disabled power request not refused");

  a_ack_free_req: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (dev_pm_req_i && pwr_allow == 4'h0) |=> (pmack_o && !pmnak_o))
    else $error("unrestricted power request not accepted");

  a_ctl_ro_zero: assert property (
    @(posedge clk_i) disable iff (srst_i)
    rd_ctl |=> (rd_valid_o && rd_data_o[31:12] == 20'h0_0000))
    else $error("control read-only bits not zero");

  a_err_reset_zero: assert property (
    @(posedge clk_i) disable iff (srst_i)
    $past(srst_i) |-> (err_reg == 16'h0000))
    else $error("error field not zero after reset");

  a_internal_sets: assert property (
    @(posedge clk_i) disable iff (srst_i)
    internal_ev |=> (err_reg[11] && (irq_fatal_set_o != irq_nonfatal_set_o)))
    else $error("internal failure did not set bit 11 and one status event");

  a_status_cause: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (irq_fatal_set_o || irq_nonfatal_set_o) |-> $past(internal_ev) && (irq_fatal_set_o == $past(err_fatal_i)))
    else $error("status event without internal failure");

  a_protocol_sets: assert property (
    @(posedge clk_i) disable iff (srst_i)
    err_ev_i.protocol |=> err_reg[10])
    else $error("protocol violation did not set bit 10");

  a_comreset_follow: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (wr_ctl && reg_req_i.wdata[3:0] == 4'h1) |=> comreset_o ##0 !phy_offline_o)
    else $error("comreset not sent for detect init 1h");

  a_speed_follow: assert property (
    @(posedge clk_i) disable iff (srst_i)
    wr_ctl |=> (speed_limit_o == $past(reg_req_i.wdata[7:4])))
    else $error("speed limit does not follow write");

  a_err_rsvd_zero: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (err_reg[15:12] == 4'h0 && err_reg[7:2] == 6'h00))
    else $error("reserved error bit set");

  a_err_sticky: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (err_reg[11] && !(wr_err && reg_req_i.wdata[11])) || (internal_ev && wr_err) |=> err_reg[11])
    else $error("internal error flag lost");

  a_err_w1c: assert property (
    @(posedge clk_i) disable iff (srst_i)
    (wr_err && reg_req_i.wdata[10] && !err_ev_i.protocol) |=> !err_reg[10])
    else $error("write one did not clear bit 10");

endmodule

// File: tb/spce_drive_model.sv
// spce_drive_model.sv: behavioural attached drive that asks for interface power states.
// assumes: shares clk_i with the port; the answer pulse comes one cycle after a request.
module spce_drive_model (
  input wire logic clk_i,
  input wire logic pmack_i,
  input wire logic pmnak_i,
  output logic dev_pm_req_o,
  output spce_pkg::spce_pm_kind_e dev_pm_kind_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle: no request, kind line parked
  initial begin
    dev_pm_req_o = 1'b0;
    dev_pm_kind_o = spce_pkg::SPCE_PM_SLUMBER;
  end
  // one-cycle request; the kind line then flips so a stale value cannot pass
  task automatic request(input spce_pkg::spce_pm_kind_e kind, output logic ack, output logic nak);
    @(negedge clk_i);
    dev_pm_req_o = 1'b1;
    dev_pm_kind_o = kind;
    @(negedge clk_i);
    dev_pm_req_o = 1'b0;
    dev_pm_kind_o = spce_pkg::spce_pm_kind_e'(~kind);
    ack = pmack_i;
    nak = pmnak_i;
  endtask
endmodule

// File: tb/spce_port_regs_tb.sv
// spce_port_regs_tb.sv: self-checking bench for the port link register block.
// assumes: inputs move on the falling edge; the drive model issues power requests and the port answers them.
module spce_port_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, srst_i, err_fatal_i, host_pm_req_i, host_pm_go_o, dev_pm_req_i, pmack_o, pmnak_o;
  logic rd_valid_o, comreset_o, phy_offline_o, irq_fatal_set_o, irq_nonfatal_set_o;
  logic [31:0] rd_data_o, q;
  logic [3:0] speed_limit_o;
  spce_pkg::spce_reg_req_s reg_req_i;
  spce_pkg::spce_err_ev_s err_ev_i;
  spce_pkg::spce_pm_kind_e host_pm_kind_i, dev_pm_kind_i;
  int fails, cmp_count;
  logic [31:0] nf, nn;
  spce_port_regs u_dut (.clk_i(clk_i), .srst_i(srst_i), .reg_req_i(reg_req_i), .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o), .err_ev_i(err_ev_i), .err_fatal_i(err_fatal_i), .host_pm_req_i(host_pm_req_i),
    .host_pm_kind_i(host_pm_kind_i), .host_pm_go_o(host_pm_go_o), .dev_pm_req_i(dev_pm_req_i),
    .dev_pm_kind_i(dev_pm_kind_i), .pmack_o(pmack_o), .pmnak_o(pmnak_o), .comreset_o(comreset_o),
    .phy_offline_o(phy_offline_o), .speed_limit_o(speed_limit_o), .irq_fatal_set_o(irq_fatal_set_o),
    .irq_nonfatal_set_o(irq_nonfatal_set_o));
  spce_drive_model u_drv (.clk_i(clk_i), .pmack_i(pmack_o), .pmnak_i(pmnak_o),
    .dev_pm_req_o(dev_pm_req_i), .dev_pm_kind_o(dev_pm_kind_i));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // 50 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  // one window access plus optional events in the same cycle; counts irq pulses in the two cycles after
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [9:0] ev, output logic [31:0] r);
    @(negedge clk_i);
    reg_req_i = '{valid: 1'b1, write: w, addr: a, wdata: d};
    err_ev_i = ev;
    @(negedge clk_i);
    reg_req_i = '0;
    err_ev_i = '0;
    r = rd_data_o;
    if (!w) chk(32'(rd_valid_o), 32'h1, "rd_valid");
    nf = 32'(irq_fatal_set_o);
    nn = 32'(irq_nonfatal_set_o);
    @(negedge clk_i);
    nf += 32'(irq_fatal_set_o);
    nn += 32'(irq_nonfatal_set_o);
  endtask
  task automatic do_reset(input int n);
    srst_i = 1'b1;
    repeat (n) @(negedge clk_i);
    srst_i = 1'b0;
  endtask
  task automatic close_out();
    $display("counts: fails=%0d cmp_count=%0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_ctl();
    bus(1'b0, 8'h2C, 32'h0, 10'h000, q);
    chk(q, 32'h0, "ctl reset");
    bus(1'b0, 8'h30, 32'h0, 10'h000, q);
    chk(q, 32'h0, "err reset");
    bus(1'b1, 8'h2C, 32'hFFFF_FFFF, 10'h000, q);
    bus(1'b0, 8'h2C, 32'h0, 10'h000, q);
    chk(q, 32'h0000_0FFF, "ctl ro");
    bus(1'b0, 8'h38, 32'h0, 10'h000, q);
    chk(q, 32'h0, "unmapped");
    bus(1'b1, 8'h2C, 32'h0000_0021, 10'h000, q);
    chk({comreset_o, phy_offline_o, speed_limit_o}, 32'h22, "comreset speed2");
    bus(1'b1, 8'h2C, 32'h0000_0014, 10'h000, q);
    chk({comreset_o, phy_offline_o, speed_limit_o}, 32'h11, "offline speed1");
    $display("done t_ctl");
  endtask
  // allow codes 0h to 3h and reserved code 5h, each with both kinds; 5h blocks both
  task automatic t_pm();
    logic [3:0] codes [5];
    logic ack, nak, dis;
    codes = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5};
    foreach (codes[c]) begin
      bus(1'b1, 8'h2C, {20'h0, codes[c], 8'h00}, 10'h000, q);
      for (int k = 0; k < 2; k++) begin
        dis = (codes[c] > 4'h3) ? 1'b1 : codes[c][k];
        host_pm_req_i = 1'b1;
        host_pm_kind_i = spce_pkg::spce_pm_kind_e'(k);
        #1 chk(32'(host_pm_go_o), 32'(!dis), "host go");
        u_drv.request(spce_pkg::spce_pm_kind_e'(k), ack, nak);
        chk({ack, nak}, dis ? 32'h1 : 32'h2, "pm answer");
      end
    end
    host_pm_req_i = 1'b0;
    $display("done t_pm");
  endtask
  // each event input lands on its error bit; internal ones also raise one irq pulse
  task automatic t_err();
    int b;
    for (int i = 0; i < 10; i++) begin
      b = (i > 4) ? 11 : (i == 4) ? 10 : (i > 1) ? i + 6 : i;
      err_fatal_i = i[0];
      bus(1'b0, 8'h00, 32'h0, 10'(1 << i), q);
      chk(32'(nf), (i > 4 && i[0]) ? 32'h1 : 32'h0, "irq fatal");
      chk(32'(nn), (i > 4 && !i[0]) ? 32'h1 : 32'h0, "irq nonfatal");
      bus(1'b0, 8'h30, 32'h0, 10'h000, q);
      chk(q, 32'h1 << b, "err bit");
      bus(1'b1, 8'h30, 32'hFFFF_FFFF, 10'h000, q);
      bus(1'b0, 8'h30, 32'h0, 10'h000, q);
      chk(q, 32'h0, "w1c");
    end
    $display("done t_err");
  endtask
  // flag survives a zero write, a clear of other bits and a clear in the event's own cycle
  task automatic t_sticky();
    bus(1'b0, 8'h00, 32'h0, 10'h010, q);
    bus(1'b1, 8'h30, 32'h0, 10'h000, q);
    bus(1'b1, 8'h30, 32'h0000_0B00, 10'h000, q);
    bus(1'b0, 8'h30, 32'h0, 10'h000, q);
    chk(q, 32'h0000_0400, "other clear");
    bus(1'b1, 8'h30, 32'h0000_0400, 10'h010, q);
    bus(1'b0, 8'h30, 32'h0, 10'h000, q);
    chk(q, 32'h0000_0400, "event wins");
    bus(1'b1, 8'h2C, 32'h0000_0021, 10'h000, q);
    do_reset(2);
    chk({comreset_o, speed_limit_o}, 32'h0, "reset outs");
    bus(1'b0, 8'h30, 32'h0, 10'h000, q);
    chk(q, 32'h0, "err rst2");
    $display("done t_sticky");
  endtask
  // bound on the whole run
  initial begin
    #200_000;
    fails++;
    $display("mismatch t=%0t timeout", $time);
    close_out();
  end
  // main sequence
  initial begin
    fails = 0;
    cmp_count = 0;
    reg_req_i = '0;
    err_ev_i = '0;
    err_fatal_i = 1'b0;
    host_pm_req_i = 1'b0;
    host_pm_kind_i = spce_pkg::SPCE_PM_PARTIAL;
    do_reset(6);
    t_ctl();
    t_pm();
    t_err();
    t_sticky();
    close_out();
  end
endmodule
